// ==== core/scan_master_defines.vh ====
`ifndef SCAN_MASTER_DEFINES_VH
`define SCAN_MASTER_DEFINES_VH

// Register port codes on the five address lines
`define A_START        5'h00
`define A_STATUS       5'h01
`define A_IRQ_EN       5'h02
`define A_IRQ_PEND     5'h03
`define A_CONFIG       5'h04
`define A_SCAN_CLOCK_DIVIDER       5'h05
`define A_POLY_EXP     5'h07
`define A_SEED_LO      5'h08
`define A_SEED_HI      5'h09
`define A_RES_LO       5'h0A
`define A_RES_HI       5'h0B
`define A_PRESET       5'h0C
`define A_WIN_SOUT     5'h0D
`define A_WIN_SIN      5'h0E
`define A_WIN_EXP      5'h0F
`define A_WIN_MASK     5'h10
`define A_VEC_PTR      5'h11
`define A_WIN_VEC      5'h12
`define A_HT_PTR       5'h13
`define A_WIN_HT       5'h14
`define A_MAC_PTR      5'h15
`define A_WIN_MAC      5'h16
`define A_SEQ_PTR      5'h17
`define A_WIN_SEQ      5'h18
`define A_BS_PTR       5'h19
`define A_WIN_BS       5'h1A

// Region base long-word addresses
`define B_SOUT         11'h000
`define B_SIN          11'h1C0
`define B_EXP          11'h380
`define B_MASK         11'h540
`define B_VEC          11'h700
`define B_HT           11'h708
`define B_MAC          11'h788
`define B_SEQ          11'h798
`define B_BS           11'h7B8

// Reset values
`define RST_CONFIG     16'h0043
`define RST_ZERO       16'h0000

// Start register fields
`define F_START_GO     0
`define F_START_VEC_LO 1
`define F_START_VEC_HI 2
// Status register fields
`define F_STAT_BUSY    0
`define F_STAT_DONE    1

// Vector fields (high long word holds bits 0x3F..0x20)
`define F_VEC_MAC_LO   0
`define F_VEC_MAC_HI   7
`define F_VEC_OTF      15

// Macro fields
`define F_MAC_CMP      31
`define F_MAC_MASK     30
`define F_MAC_SYNC     23
`define F_MAC_EN8      22
`define F_MAC_EN7      21
`define F_MAC_HT_LO    18
`define F_MAC_HT_HI    20
`define F_MAC_TYPE_LO  16
`define F_MAC_TYPE_HI  17
`define F_MAC_LOOP     7
`define F_MAC_TC       8
`define F_MAC_FIRST_HI 6
`define F_MAC_LAST_LO  9

// Macro types
`define T_BIST         2'b00
`define T_SHIFT        2'b01
`define T_SHIFT_CAP    2'b10
`define T_STATE        2'b11

// Header/trailer usage codes
`define HT_IGNORE      3'b000
`define HT_RESERVED    3'b111

`define MEM_WORDS      2048
`define FIFO_DEPTH     32
`define FIFO_AW        5
`define FIFO_W         43

`endif

// ==== core/word_fifo.v ====
`timescale 1ns/1ps
module word_fifo #(
  parameter W  = 43,
  parameter D  = 32,
  parameter AW = 5
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rstn,
  // Fill side
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  // Drain side
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] store [0:D-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0]   count;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = (count != D[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = store[rd_ptr];

  always @(posedge clk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ==== core/scan_master_regs.v ====
`timescale 1ns/1ps
`include "scan_master_defines.vh"
module scan_master_regs (
  // System
  input  wire        clk,
  input  wire        rstn,
  // Processor port
  input  wire        ce_n,
  input  wire        stb_n,
  input  wire        rw,
  input  wire [4:0]  addr,
  input  wire [15:0] data_in,
  output reg  [15:0] data_out,
  output reg         data_oe,
  output reg         dtack_n,
  output reg         dtack_oe,
  // Scan pins
  output reg         scan_clock_out,
  output reg         mode_select_out,
  // Decoded descriptor of the running vector
  output reg  [31:0] shift_length,
  output reg  [7:0]  macro_number,
  output reg         on_the_fly_load,
  output reg         compare_enable,
  output reg         compare_masked,
  output reg         sync_enable,
  output reg  [1:0]  macro_type,
  output reg         use_instr_header,
  output reg         use_instr_trailer,
  output reg         use_data_header,
  output reg         use_data_trailer
);
  localparam S_IDLE = 3'd0, S_RUN = 3'd1, S_WAIT = 3'd2, S_ACK = 3'd3, S_REL = 3'd4;
  localparam E_IDLE = 3'd0, E_V0 = 3'd1, E_V1 = 3'd2, E_MAC = 3'd3, E_DEC = 3'd4,
             E_STEP = 3'd5, E_END = 3'd6;

  // Strobe pins are asynchronous to clk
  reg [1:0] ce_sync;
  reg [1:0] stb_sync;
  reg       stb_last;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ce_sync  <= 2'b11;
      stb_sync <= 2'b11;
      stb_last <= 1'b1;
    end else begin
      ce_sync  <= {ce_sync[0], ce_n};
      stb_sync <= {stb_sync[0], stb_n};
      stb_last <= stb_sync[1];
    end
  end
  wire stb_fall = stb_last && !stb_sync[1] && !ce_sync[1];
  wire stb_rise = !stb_last && stb_sync[1];

  reg [31:0] mem [0:`MEM_WORDS-1];
  reg [2:0]  bus_state;
  reg [15:0] start_control, status_flags, irq_enable_control, irq_pending_flags;
  reg [15:0] device_config, scan_clock_divider, signature_poly_exponent;
  reg [15:0] signature_seed_low, signature_seed_high;
  reg [15:0] signature_result_low, signature_result_high;
  reg [15:0] buffer_pointer_preset;
  reg [15:0] vector_pointer, hdr_trl_pointer, macro_pointer;
  reg [15:0] sequencer_pointer, bridge_support_pointer;
  reg [15:0] sout_ptr, sin_ptr, exp_ptr, mask_ptr;
  reg [15:0] hi_hold;
  reg [15:0] lo_read;
  reg        second;
  reg        pair_half;
  reg [4:0]  a_q;
  reg        rw_q;
  reg [15:0] d_q;
  reg [2:0]  eng;
  reg [10:0] eng_addr;
  reg [31:0] rd_word;

  // Window address and pointer select
  reg        is_win;
  reg [10:0] base;
  reg [15:0] ptr;
  always @* begin
    is_win = 1'b1;
    base   = `B_SOUT;
    ptr    = sout_ptr;
    case (a_q)
      `A_WIN_SOUT: begin base = `B_SOUT; ptr = sout_ptr; end
      `A_WIN_SIN:  begin base = `B_SIN;  ptr = sin_ptr;  end
      `A_WIN_EXP:  begin base = `B_EXP;  ptr = exp_ptr;  end
      `A_WIN_MASK: begin base = `B_MASK; ptr = mask_ptr; end
      `A_WIN_VEC:  begin base = `B_VEC;  ptr = vector_pointer; end
      `A_WIN_HT:   begin base = `B_HT;   ptr = hdr_trl_pointer; end
      `A_WIN_MAC:  begin base = `B_MAC;  ptr = macro_pointer; end
      `A_WIN_SEQ:  begin base = `B_SEQ;  ptr = sequencer_pointer; end
      `A_WIN_BS:   begin base = `B_BS;   ptr = bridge_support_pointer; end
      default:     is_win = 1'b0;
    endcase
  end
  wire [10:0] win_addr = base + ptr[10:0];

  // Register read mux
  reg [15:0] reg_rd;
  always @* begin
    case (a_q)
      `A_START:    reg_rd = start_control;
      `A_STATUS:   reg_rd = status_flags;
      `A_IRQ_EN:   reg_rd = irq_enable_control;
      `A_IRQ_PEND: reg_rd = irq_pending_flags;
      `A_CONFIG:   reg_rd = device_config;
      `A_SCAN_CLOCK_DIVIDER:   reg_rd = scan_clock_divider;
      `A_POLY_EXP: reg_rd = signature_poly_exponent;
      `A_SEED_LO:  reg_rd = signature_seed_low;
      `A_SEED_HI:  reg_rd = signature_seed_high;
      `A_RES_LO:   reg_rd = signature_result_low;
      `A_RES_HI:   reg_rd = signature_result_high;
      `A_PRESET:   reg_rd = buffer_pointer_preset;
      `A_VEC_PTR:  reg_rd = vector_pointer;
      `A_HT_PTR:   reg_rd = hdr_trl_pointer;
      `A_MAC_PTR:  reg_rd = macro_pointer;
      `A_SEQ_PTR:  reg_rd = sequencer_pointer;
      `A_BS_PTR:   reg_rd = bridge_support_pointer;
      default:     reg_rd = `RST_ZERO;
    endcase
  end

  // Posted long-word writes; a full FIFO holds off the processor acknowledge
  wire        f_in_ready;
  wire        f_out_valid;
  wire [42:0] f_out_data;
  wire        eng_reads = (eng == E_V0) || (eng == E_V1) || (eng == E_MAC);
  wire        mem_push = (bus_state == S_RUN) && is_win && !rw_q && second;
  word_fifo #(.W(`FIFO_W), .D(`FIFO_DEPTH), .AW(`FIFO_AW)) post_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (mem_push),
    .in_ready  (f_in_ready),
    .in_data   ({win_addr, hi_hold, d_q}),
    .out_valid (f_out_valid),
    .out_ready (1'b1),
    .out_data  (f_out_data)
  );

  // Read waits for posted writes to land and for the engine to free the port
  wire rd_go = (bus_state == S_RUN) && is_win && rw_q && !second && !f_out_valid && !eng_reads;
  always @(posedge clk) begin
    if (f_out_valid) begin
      mem[f_out_data[42:32]] <= f_out_data[31:0];
    end
    rd_word <= mem[eng_reads ? eng_addr : win_addr];
  end

  // Scan-out, expected and mask pointers step on the second half of a long-word write, scan-in on a read; the others never step
  wire step = (bus_state == S_RUN) && is_win && second && (rw_q || f_in_ready);
  wire [15:0] pset = data_in;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_state <= S_IDLE;
      data_out <= `RST_ZERO; data_oe <= 1'b0; dtack_n <= 1'b1; dtack_oe <= 1'b0;
      a_q <= 5'h00; rw_q <= 1'b0; d_q <= `RST_ZERO; hi_hold <= `RST_ZERO;
      lo_read <= `RST_ZERO; second <= 1'b0; pair_half <= 1'b0;
      irq_enable_control <= `RST_ZERO; irq_pending_flags <= `RST_ZERO;
      device_config <= `RST_CONFIG; scan_clock_divider <= `RST_ZERO;
      signature_poly_exponent <= `RST_ZERO;
      signature_seed_low <= `RST_ZERO; signature_seed_high <= `RST_ZERO;
      signature_result_low <= `RST_ZERO; signature_result_high <= `RST_ZERO;
      buffer_pointer_preset <= `RST_ZERO;
      vector_pointer <= `RST_ZERO; hdr_trl_pointer <= `RST_ZERO; macro_pointer <= `RST_ZERO;
      sequencer_pointer <= `RST_ZERO; bridge_support_pointer <= `RST_ZERO;
      sout_ptr <= `RST_ZERO; sin_ptr <= `RST_ZERO; exp_ptr <= `RST_ZERO; mask_ptr <= `RST_ZERO;
    end else begin
      case (bus_state)
        S_IDLE: begin
          if (stb_fall) begin
            a_q <= addr; rw_q <= rw; d_q <= data_in;
            bus_state <= S_RUN;
          end
        end
        S_RUN: begin
          if (!is_win) begin
            data_out <= reg_rd;
            bus_state <= S_ACK;
            if (a_q == `A_SEED_LO || a_q == `A_SEED_HI ||
                a_q == `A_RES_LO || a_q == `A_RES_HI) begin
              pair_half <= ~pair_half;
            end else begin
              pair_half <= 1'b0;
            end
            if (!rw_q) begin
              case (a_q)
                `A_IRQ_EN:   irq_enable_control <= d_q;
                `A_IRQ_PEND: irq_pending_flags <= irq_pending_flags & ~d_q;
                `A_CONFIG:   device_config <= d_q;
                `A_SCAN_CLOCK_DIVIDER:   scan_clock_divider <= d_q;
                `A_POLY_EXP: signature_poly_exponent <= d_q;
                `A_SEED_LO:  signature_seed_low <= d_q;
                `A_SEED_HI:  signature_seed_high <= d_q;
                `A_RES_LO:   signature_result_low <= d_q;
                `A_RES_HI:   signature_result_high <= d_q;
                `A_PRESET: begin
                  buffer_pointer_preset <= d_q;
                  sout_ptr <= d_q; sin_ptr <= d_q;
                  exp_ptr <= d_q; mask_ptr <= d_q;
                end
                `A_VEC_PTR: vector_pointer <= d_q;
                `A_HT_PTR:  hdr_trl_pointer <= d_q;
                `A_MAC_PTR: macro_pointer <= d_q;
                `A_SEQ_PTR: sequencer_pointer <= d_q;
                `A_BS_PTR:  bridge_support_pointer <= d_q;
                default: ;
              endcase
            end
          end else if (rw_q && !second) begin
            if (rd_go) begin
              bus_state <= S_WAIT;
            end
          end else if (step) begin
            // Big-endian: high word travels first
            data_out <= lo_read;
            second <= 1'b0;
            bus_state <= S_ACK;
            case (a_q)
              `A_WIN_SIN:  if (rw_q) sin_ptr <= sin_ptr + 16'h0001;
              `A_WIN_SOUT: if (!rw_q) sout_ptr <= sout_ptr + 16'h0001;
              `A_WIN_EXP:  if (!rw_q) exp_ptr <= exp_ptr + 16'h0001;
              `A_WIN_MASK: if (!rw_q) mask_ptr <= mask_ptr + 16'h0001;
              default: ;
            endcase
          end else if (!rw_q && !second) begin
            hi_hold <= d_q;
            second <= 1'b1;
            bus_state <= S_ACK;
          end
        end
        S_WAIT: begin
          data_out <= rd_word[31:16];
          lo_read <= rd_word[15:0];
          second <= 1'b1;
          bus_state <= S_ACK;
        end
        S_ACK: begin
          data_oe <= rw_q;
          dtack_n <= 1'b0;
          dtack_oe <= 1'b1;
          bus_state <= S_REL;
        end
        default: begin
          if (stb_rise || stb_sync[1]) begin
            data_oe <= 1'b0; dtack_n <= 1'b1; dtack_oe <= 1'b0;
            bus_state <= S_IDLE;
          end
        end
      endcase
    end
  end

  // Scan clock: each half period lasts divider+1 system clocks
  reg  [15:0] div_cnt;
  wire        half = (div_cnt == scan_clock_divider);
  wire        fall = half && scan_clock_out;
  reg  [31:0] vec_macro_word;
  reg  [31:0] mac;
  reg  [3:0]  idx;
  reg  [31:0] loop_cnt;
  wire        go_wr = (bus_state == S_RUN) && !rw_q && (a_q == `A_START) && d_q[`F_START_GO];
  wire [1:0]  typ = mac[`F_MAC_TYPE_HI:`F_MAC_TYPE_LO];
  wire        is_shift = (typ == `T_SHIFT) || (typ == `T_SHIFT_CAP);
  wire        loops = (typ != `T_STATE);
  wire        use7 = mac[`F_MAC_EN7] && !is_shift;
  wire        use8 = mac[`F_MAC_EN8] && !is_shift;
  // Skipped positions cost no scan clock, so every rising edge samples a real bit
  wire [3:0]  idx_inc = idx + 4'h1;
  wire        skip7 = loops ? (loop_cnt == 32'h0000_0000) : !use7;
  wire        skip8 = is_shift || !use8;
  reg  [3:0]  next_idx;
  always @* begin
    next_idx = idx_inc;
    if (next_idx == 4'h7 && skip7) next_idx = 4'h8;
    if (next_idx == 4'h8 && skip8) next_idx = 4'h9;
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      eng <= E_IDLE; eng_addr <= 11'h000; div_cnt <= `RST_ZERO;
      scan_clock_out <= 1'b0; mode_select_out <= 1'b1;
      start_control <= `RST_ZERO; status_flags <= `RST_ZERO;
      vec_macro_word <= 32'h0000_0000; mac <= 32'h0000_0000;
      idx <= 4'h0; loop_cnt <= 32'h0000_0000;
      shift_length <= 32'h0000_0000; macro_number <= 8'h00; on_the_fly_load <= 1'b0;
      compare_enable <= 1'b0; compare_masked <= 1'b0; sync_enable <= 1'b0;
      macro_type <= 2'b00; use_instr_header <= 1'b0; use_instr_trailer <= 1'b0;
      use_data_header <= 1'b0; use_data_trailer <= 1'b0;
    end else begin
      if ((bus_state == S_RUN) && !rw_q && (a_q == `A_START)) begin
        start_control <= d_q;
      end else if (eng == E_END) begin
        start_control[`F_START_GO] <= 1'b0;
      end
      if ((bus_state == S_RUN) && !rw_q && (a_q == `A_STATUS)) begin
        status_flags <= d_q;
      end else begin
        status_flags[`F_STAT_BUSY] <= (eng != E_IDLE);
        if (eng == E_END) status_flags[`F_STAT_DONE] <= 1'b1;
      end
      div_cnt <= (half || (eng != E_STEP && eng != E_END)) ? `RST_ZERO : div_cnt + 16'h0001;
      if ((eng == E_STEP || eng == E_END) && half) scan_clock_out <= ~scan_clock_out;
      case (eng)
        E_IDLE: begin
          scan_clock_out <= 1'b0;
          if (go_wr) begin
            eng_addr <= `B_VEC + {7'h00, d_q[`F_START_VEC_HI:`F_START_VEC_LO], 1'b0};
            eng <= E_V0;
          end
        end
        E_V0: begin
          eng_addr <= eng_addr + 11'h001;
          eng <= E_V1;
        end
        E_V1: begin
          vec_macro_word <= rd_word;
          eng_addr <= `B_MAC + {7'h00, rd_word[`F_VEC_MAC_LO+3:`F_VEC_MAC_LO]};
          eng <= E_MAC;
        end
        E_MAC: begin
          shift_length <= rd_word;
          macro_number <= vec_macro_word[`F_VEC_MAC_HI:`F_VEC_MAC_LO];
          on_the_fly_load <= vec_macro_word[`F_VEC_OTF];
          eng <= E_DEC;
        end
        E_DEC: begin
          mac <= rd_word;
          compare_enable <= rd_word[`F_MAC_CMP];
          compare_masked <= rd_word[`F_MAC_MASK];
          sync_enable <= rd_word[`F_MAC_SYNC];
          macro_type <= rd_word[`F_MAC_TYPE_HI:`F_MAC_TYPE_LO];
          case (rd_word[`F_MAC_HT_HI:`F_MAC_HT_LO])
            3'b001: {use_instr_header, use_instr_trailer} <= 2'b10;
            3'b010: {use_instr_header, use_instr_trailer} <= 2'b01;
            3'b011: {use_instr_header, use_instr_trailer} <= 2'b11;
            default: {use_instr_header, use_instr_trailer} <= 2'b00;
          endcase
          case (rd_word[`F_MAC_HT_HI:`F_MAC_HT_LO])
            3'b100: {use_data_header, use_data_trailer} <= 2'b10;
            3'b101: {use_data_header, use_data_trailer} <= 2'b01;
            3'b110: {use_data_header, use_data_trailer} <= 2'b11;
            default: {use_data_header, use_data_trailer} <= 2'b00;
          endcase
          // First bit stands before the first rising scan clock
          mode_select_out <= rd_word[0];
          idx <= 4'h1;
          loop_cnt <= shift_length;
          eng <= E_STEP;
        end
        E_STEP: begin
          // Mode line only changes as the scan clock falls
          if (fall) begin
            if (idx == `F_MAC_LOOP && loops) begin
              loop_cnt <= loop_cnt - 32'h0000_0001;
              if (loop_cnt == 32'h0000_0001) idx <= next_idx;
              if (is_shift && loop_cnt == 32'h0000_0001) begin
                mode_select_out <= mac[`F_MAC_TC];
              end else begin
                mode_select_out <= mac[`F_MAC_LOOP];
              end
            end else begin
              mode_select_out <= mac[idx];
              idx <= next_idx;
              if (idx == 4'hF) eng <= E_END;
            end
          end
        end
        E_END: begin
          // One more clock period so the last bit is sampled
          if (fall) eng <= E_IDLE;
        end
        default: eng <= E_IDLE;
      endcase
    end
  end
endmodule

// ==== test/scan_master_monitor.sv ====
`timescale 1ns/1ps
module scan_master_monitor (
  // System
  input logic        clk,
  input logic        rstn,
  // Processor port
  input logic        ce_n,
  input logic        stb_n,
  input logic        rw,
  input logic [15:0] data_out,
  input logic        data_oe,
  input logic        dtack_n,
  input logic        dtack_oe,
  // Scan side
  input logic        scan_clock_out,
  input logic        mode_select_out,
  input logic        use_instr_header,
  input logic        use_instr_trailer,
  input logic        use_data_header,
  input logic        use_data_trailer
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence strobe_s;
    $fell(stb_n) && !ce_n;
  endsequence
  sequence ack_s;
    ##[4:60] !dtack_n;
  endsequence
  ack_latency_a: assert property (strobe_s |-> ack_s)
    else $error("no acknowledge after strobe");
  ack_release_a: assert property ($rose(stb_n) |-> ##[1:6] dtack_n)
    else $error("acknowledge not released");
  read_hold_a: assert property ($fell(dtack_n) && rw |-> data_oe throughout !dtack_n [*2])
    else $error("read data not driven with acknowledge");
  data_stable_a: assert property (data_oe && !dtack_n && $past(!dtack_n) |-> $stable(data_out))
    else $error("read data moved during acknowledge");
  ack_drive_a: assert property (!dtack_n |-> dtack_oe)
    else $error("acknowledge low while released");
  read_only_a: assert property ($rose(data_oe) |-> rw)
    else $error("data driven on a write");
  ht_exclusive_a: assert property (!((use_instr_header || use_instr_trailer)
    && (use_data_header || use_data_trailer))) else $error("instruction and data usage together");
  mode_hold_a: assert property ($changed(mode_select_out) |-> !scan_clock_out)
    else $error("mode select changed with scan clock high");
endmodule
bind scan_master_regs scan_master_monitor scan_master_monitor_i (.clk(clk), .rstn(rstn),
  .ce_n(ce_n), .stb_n(stb_n), .rw(rw), .data_out(data_out), .data_oe(data_oe),
  .dtack_n(dtack_n), .dtack_oe(dtack_oe), .scan_clock_out(scan_clock_out),
  .mode_select_out(mode_select_out), .use_instr_header(use_instr_header),
  .use_instr_trailer(use_instr_trailer), .use_data_header(use_data_header),
  .use_data_trailer(use_data_trailer));

// ==== test/scan_proc_model.sv ====
`timescale 1ns/1ps
module scan_proc_model (
  // Clock
  input  wire        clk,
  // Processor port
  output reg         ce_n,
  output reg         stb_n,
  output reg         rw,
  output reg  [4:0]  addr,
  output reg  [15:0] data_in,
  input  wire [15:0] data_out,
  input  wire        dtack_n,
  input  wire        dtack_oe
);
  integer timeouts = 0;
  initial begin
    {ce_n, stb_n, rw, addr, data_in} = {3'b111, 5'h00, 16'h0000};
  end
  // Everything held until the ack edge; idle data shows the inverse of the last value
  task automatic acc(input logic r, input logic [4:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    int n;
    @(negedge clk);
    {ce_n, stb_n, rw, addr} <= {2'b00, r, a};
    data_in <= r ? ~data_in : d;
    for (n = 0; n < 99 && dtack_n !== 1'b0; n++) @(posedge clk) #1;
    if (n == 99) timeouts++;
    q = data_out;
    @(negedge clk);
    {ce_n, stb_n} <= 2'b11;
    for (n = 0; n < 99 && dtack_oe !== 1'b0; n++) @(posedge clk) #1;
    if (n == 99) timeouts++;
    @(negedge clk);
    rw <= 1'b1;
    data_in <= ~data_in;
  endtask
endmodule

// ==== test/scan_master_register_memory_map_tb_top.sv ====
`timescale 1ns/1ps
module scan_master_register_memory_map_tb_top;
  logic        clk;
  logic        rstn;
  wire         ce_n, stb_n, rw, data_oe, dtack_n, dtack_oe, scan_clock_out, mode_select_out;
  wire  [4:0]  addr;
  wire  [15:0] data_in, data_out;
  wire  [49:0] dec;
  integer      errors = 0;
  integer      tests_run = 0;
  logic [15:0] m_reg [0:31];
  logic [15:0] bptr [0:3];
  logic [31:0] mem [int];
  logic [49:0] snap;
  logic        mso_q [$];
  logic [4:0]  wcode [0:6] = '{5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h12, 5'h14, 5'h16};
  logic [10:0] wbase [0:6] = '{11'h000, 11'h1C0, 11'h380, 11'h540, 11'h700, 11'h708, 11'h788};
  scan_proc_model proc_i (.clk(clk), .ce_n(ce_n), .stb_n(stb_n), .rw(rw), .addr(addr),
    .data_in(data_in), .data_out(data_out), .dtack_n(dtack_n), .dtack_oe(dtack_oe));
  scan_master_regs scan_master_regs_i (.clk(clk), .rstn(rstn), .ce_n(ce_n), .stb_n(stb_n),
    .rw(rw), .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .dtack_n(dtack_n), .dtack_oe(dtack_oe), .scan_clock_out(scan_clock_out),
    .mode_select_out(mode_select_out), .shift_length(dec[49:18]), .macro_number(dec[17:10]),
    .on_the_fly_load(dec[9]), .compare_enable(dec[8]), .compare_masked(dec[7]),
    .sync_enable(dec[6]), .macro_type(dec[5:4]), .use_instr_header(dec[3]),
    .use_instr_trailer(dec[2]), .use_data_header(dec[1]), .use_data_trailer(dec[0]));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic stop_test;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic acc(input logic r, input logic [4:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    proc_i.acc(r, a, d, q);
    if (proc_i.timeouts != 0) begin
      errors++;
      $display("CHECK FAILED %0t bus handshake timeout", $time);
      stop_test;
    end
  endtask
  // Mirror only what the bench reads back; unmapped codes stay zero
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] q;
    acc(1'b0, a, d, q);
    if (a == 5'h0C) for (int i = 0; i < 4; i++) bptr[i] = d;
    if (a inside {[5'h08:5'h0C], 5'h11, 5'h13, 5'h15, 5'h17, 5'h19}) m_reg[a] = d;
  endtask
  task automatic rdc(input logic [4:0] a);
    logic [15:0] q;
    acc(1'b1, a, 16'h0000, q);
    chk(q, m_reg[a], "register");
  endtask
  function automatic int wa(int k);
    return (wbase[k] + (k < 4 ? bptr[k] : m_reg[wcode[k] - 5'h01])) & 32'h7FF;
  endfunction
  task automatic wlw(int k, logic [31:0] d);
    wr(wcode[k], d[31:16]);
    wr(wcode[k], d[15:0]);
    mem[wa(k)] = d;
    if (k == 0 || k == 2 || k == 3) bptr[k]++;
  endtask
  task automatic rlw(int k);
    logic [15:0] h, l;
    acc(1'b1, wcode[k], 16'h0000, h);
    acc(1'b1, wcode[k], 16'h0000, l);
    chk({h, l}, mem[wa(k)], "window");
    if (k == 1) bptr[1]++;
  endtask
  always @(posedge scan_clock_out) begin
    if (mso_q.size() == 0) snap = dec;
    mso_q.push_back(mode_select_out);
  end
  initial begin
    logic [31:0] m;
    logic [7:0]  mn;
    logic [15:0] q, p;
    int          n, t, u;
    rstn = 1'b0;
    void'($urandom(32'h1FD4C854));
    for (int a = 0; a < 32; a++) m_reg[a] = (a == 4) ? 16'h0043 : 16'h0000;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    for (int a = 0; a < 32; a++) if (!(a inside {[13:16], 18, 20, 22, 24, 26})) rdc(a);
    wr(5'h06, 16'hFFFF);
    wr(5'h1B, 16'hFFFF);
    rdc(5'h06);
    rdc(5'h1B);
    for (int a = 8; a < 13; a++) wr(a, $urandom);
    for (int a = 8; a < 13; a++) rdc(a);
    for (int a = 17; a < 27; a += 2) wr(a, $urandom);
    for (int a = 17; a < 27; a += 2) rdc(a);
    // Back-to-back long words; the write FIFO drains each one before the next arrives
    p = 16'h0010 + ($urandom & 16'h00FF);
    wr(5'h0C, p);
    repeat (40) wlw(0, $urandom);
    for (int i = 0; i < 40; i++) begin
      wr(5'h0C, p + i);
      rlw(0);
    end
    wr(5'h0C, p);
    wlw(2, $urandom);
    wlw(3, $urandom);
    wlw(1, $urandom);
    wr(5'h0C, p + 1);
    wlw(1, $urandom);
    wr(5'h0C, p);
    rlw(0);
    rlw(2);
    rlw(3);
    rlw(1);
    rlw(1);
    for (int k = 0; k < 4; k++) begin
      wr(5'h13, k * 32);
      wlw(5, 32'h0000_0008 + k);
    end
    wr(5'h13, 16'h0021);
    wlw(5, $urandom);
    rlw(5);
    wr(5'h13, 16'h0040);
    rlw(5);
    for (int i = 0; i < 8; i++) begin
      mn = $urandom;
      m = $urandom & 32'hC0FF_FFFF;
      m[20:18] = i;
      m[17:16] = i % 4;
      t = 2 * (i % 4);
      q = $urandom;
      wr(5'h11, t);
      wlw(4, {q, i[0], 7'h00, mn});
      wr(5'h11, t + 1);
      wlw(4, 32'd2);
      wr(5'h15, mn[3:0]);
      wlw(6, m);
      mso_q.delete();
      wr(5'h00, {13'h0000, t[2:1], 1'b1});
      n = 0;
      do begin
        acc(1'b1, 5'h01, 16'h0000, q);
        n++;
      end while ((q[0] !== 1'b0 || mso_q.size() < 14) && n < 100);
      if (n >= 100) begin
        errors++;
        $display("CHECK FAILED %0t engine never finished", $time);
        stop_test;
      end
      u = m[20:18];
      chk(snap, {32'd2, mn, i[0], m[31], m[30], m[23], m[17:16], u == 1 || u == 3,
        u == 2 || u == 3, u == 4 || u == 6, u == 5 || u == 6}, "decode");
      n = 14 + (m[17:16] == 2'b11 ? m[21] : 2) + (m[17] == m[16] ? m[22] : 0);
      chk(mso_q.size(), n, "scan clocks");
      for (int j = 0; j < 7; j++) chk({mso_q[j], mso_q[n - 7 + j]}, {m[j], m[9 + j]}, "mode");
      if (m[17] ^ m[16]) chk(mso_q[8], m[8], "terminal bit");
      if (m[17:16] != 2'b11) chk(mso_q[7], m[7], "loop bit");
    end
    stop_test;
  end
endmodule
